// file: common/afs_defines.svh
/*
 * Offsets, field positions, reset values and sizes of the converter
 * output-format block.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets (low address bits only)
// ----------------------------------------------------------------------
`define AFS_ADDR_W            12
`define AFS_ADDR_CTRL         12'h000
`define AFS_ADDR_STATUS       12'h004
`define AFS_ADDR_DATA         12'h008
`define AFS_ADDR_LATENCY      12'h00C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AFS_CTRL_SEL_LSB      0
`define AFS_CTRL_SEL_MSB      1
`define AFS_CTRL_CAPTURE_BIT  2
`define AFS_STAT_TWOS_BIT     0
`define AFS_STAT_DCS_BIT      1
`define AFS_STAT_OVF_BIT      2
`define AFS_STAT_EMPTY_BIT    3
`define AFS_STAT_LVL_LSB      4
`define AFS_STAT_RUN_BIT      8

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define AFS_CTRL_RESET        3'h4
`define AFS_WORD_W            12
`define AFS_RAW_W             14
`define AFS_FIFO_DEPTH        8
`define AFS_LATENCY_DEF       8
`define AFS_HSIZE_WORD        3'h2
`define AFS_DCS_DUTY_MIN_PCT  30
`define AFS_DCS_DUTY_MAX_PCT  70

`endif

// file: common/afs_pkg.sv
/*
 * Types of the converter output-format block.
 * Assumes nothing of its surroundings.
 */
package afs_pkg;

    // ------------------------------------------------------------------
    // four-level select, encoded
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AFS_SEL_GROUND     = 2'h0,
        AFS_SEL_ONE_THIRD  = 2'h1,
        AFS_SEL_TWO_THIRDS = 2'h2,
        AFS_SEL_SUPPLY     = 2'h3
    } afs_sel_t;

    // ------------------------------------------------------------------
    // run sequencing states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        AFS_ST_IDLE = 3'h1,
        AFS_ST_FILL = 3'h2,
        AFS_ST_RUN  = 3'h4
    } afs_state_t;

endpackage : afs_pkg

// file: common/afs_stream_if.sv
/*
 * Stream carrier between the block's top and its sample FIFO.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
interface afs_stream_if #(
    parameter int WIDTH = 24,
    parameter int LVL_W = 4
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;
    logic [LVL_W-1:0] level;

    modport fill (output wr_valid, wr_data, rd_ready,
                  input  wr_ready, rd_valid, rd_data, level);
    modport fifo (input  wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data, level);
endinterface : afs_stream_if

// file: core/afs_coder.sv
/*
 * Clipping, output coding and fixed-latency pipeline for both channels.
 * Assumes raw samples are signed, one per enabled clock.
 */
`timescale 1ns/100ps
module afs_coder #(
    parameter int RAW_W   = 14,
    parameter int WORD_W  = 12,
    parameter int LATENCY = 8
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    // samples and coding
    input  wire logic [RAW_W-1:0]  i_raw_a,
    input  wire logic [RAW_W-1:0]  i_raw_b,
    input  wire logic              i_twos,
    // coded words
    output logic      [WORD_W-1:0] o_word_a,
    output logic      [WORD_W-1:0] o_word_b
);
    if (LATENCY < 1 || RAW_W < WORD_W || WORD_W < 2) begin : g_bad
        $error("afs_coder: latency must be at least 1 and raw not narrower");
    end

    localparam int MAX_I = (1 << (WORD_W - 1)) - 1;
    localparam logic signed [RAW_W-1:0] SAT_HI = RAW_W'(MAX_I);
    localparam logic signed [RAW_W-1:0] SAT_LO = RAW_W'(-MAX_I - 1);

    // clip to full scale, then code
    function automatic logic [WORD_W-1:0] afs_code(
        input logic signed [RAW_W-1:0] raw,
        input logic                    twos
    );
        logic [WORD_W-1:0] c;
        c = (raw > SAT_HI) ? SAT_HI[WORD_W-1:0] :
            (raw < SAT_LO) ? SAT_LO[WORD_W-1:0] : raw[WORD_W-1:0];
        afs_code = twos ? c : {~c[WORD_W-1], c[WORD_W-2:0]};
    endfunction : afs_code

    logic [WORD_W-1:0] pipe_a_reg [0:LATENCY-1];
    logic [WORD_W-1:0] pipe_b_reg [0:LATENCY-1];
    wire  [WORD_W-1:0] code_a;
    wire  [WORD_W-1:0] code_b;

    assign code_a   = afs_code($signed(i_raw_a), i_twos);
    assign code_b   = afs_code($signed(i_raw_b), i_twos);
    assign o_word_a = pipe_a_reg[LATENCY-1];
    assign o_word_b = pipe_b_reg[LATENCY-1];

    // same depth for both channels
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_a_reg[i] <= '0;
                pipe_b_reg[i] <= '0;
            end
        end else if (i_ce) begin
            pipe_a_reg[0] <= code_a;
            pipe_b_reg[0] <= code_b;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_a_reg[i] <= pipe_a_reg[i-1];
                pipe_b_reg[i] <= pipe_b_reg[i-1];
            end
        end
    end

endmodule : afs_coder

// file: core/afs_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes a synchronous active-low reset and a shared clock enable.
 */
`timescale 1ns/100ps
module afs_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // stream
    afs_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(s.level) != AW + 1) begin : g_bad
        $error("afs_fifo: depth must be a power of two and match level width");
    end

    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push;
    wire              pop;

    assign s.wr_ready = (count_reg != DEPTH[AW:0]);
    assign s.rd_valid = (count_reg != '0);
    assign s.rd_data  = mem_reg[rd_ptr_reg];
    assign s.level    = count_reg;
    assign push       = i_ce & s.wr_valid & s.wr_ready;
    assign pop        = i_ce & s.rd_ready & s.rd_valid;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= s.wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : afs_fifo

// file: core/afs_top.sv
/*
 * Output-format and stabilizer control of a dual-channel 12-bit converter,
 * with coded words on pins, an 8-word capture FIFO and an AHB-Lite slave.
 * Assumes all inputs synchronous to I_CLOCK and a single bus slave.
 */
// Notes on behaviour
// - offset binary: zero, top-bit-only, all ones
// - two's complement: top-bit-only, zero, max positive
// - supply select: two's complement, stabilizer bypassed
// - ground select: offset binary, stabilizer off
// - two-thirds select: two's complement, stabilizer on
// - one-third select: offset binary, stabilizer on
// - stabilizer accepts 30 to 70 percent duty
// - serial enable high: select pin ignored
// - overrange inputs saturate at full-scale codes
// - one new word per sample clock, fixed lag
`timescale 1ns/100ps
`include "afs_defines.svh"
module afs_top
    import afs_pkg::*;
#(
    parameter int RAW_W      = `AFS_RAW_W,
    parameter int WORD_W     = `AFS_WORD_W,
    parameter int LATENCY    = `AFS_LATENCY_DEF,
    parameter int FIFO_DEPTH = `AFS_FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic              I_CLOCK,
    input  wire logic              I_RESET_N,
    input  wire logic              I_CE,
    // converter side
    input  wire logic [RAW_W-1:0]  I_SAMPLE_A,
    input  wire logic [RAW_W-1:0]  I_SAMPLE_B,
    input  wire logic [1:0]        I_FORMAT_STABILIZER_SELECT,
    input  wire logic              I_SERIAL_EN,
    input  wire logic              I_POWER_DOWN_INPUT,
    // parallel output words
    output logic      [WORD_W-1:0] O_CHANNEL_A_WORD,
    output logic      [WORD_W-1:0] O_CHANNEL_B_WORD,
    output logic                   O_OUTPUT_WORD_STROBE,
    output logic                   O_TWOS_COMPLEMENT,
    output logic                   O_DUTY_CYCLE_STABILIZER,
    // AHB-Lite slave
    input  wire logic              I_HSEL,
    input  wire logic [31:0]       I_HADDR,
    input  wire logic [1:0]        I_HTRANS,
    input  wire logic              I_HWRITE,
    input  wire logic [2:0]        I_HSIZE,
    input  wire logic [31:0]       I_HWDATA,
    input  wire logic              I_HREADY,
    output logic      [31:0]       O_HRDATA,
    output logic                   O_HREADYOUT,
    output logic                   O_HRESP
);
    localparam int FIFO_W = 2 * WORD_W;
    localparam int LVL_W  = $clog2(FIFO_DEPTH) + 1;
    localparam int CNT_W  = $clog2(LATENCY + 1);

    if (FIFO_W > 32 || LVL_W > 4 || LATENCY < 1) begin : g_bad
        $error("afs_top: word pair must fit 32 bits, depth at most 8");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    afs_stream_if #(.WIDTH(FIFO_W), .LVL_W(LVL_W)) fifo_if ();

    afs_state_t           state_reg;
    afs_state_t           state_next;
    logic [CNT_W-1:0]     fill_cnt_reg;
    logic [CNT_W-1:0]     fill_cnt_next;
    logic [1:0]           ctrl_sel_reg;
    logic                 ctrl_capture_reg;
    logic                 ovf_reg;
    logic                 ovf_next;
    logic                 wr_pend_reg;
    logic [`AFS_ADDR_W-1:0] addr_reg;
    logic [WORD_W-1:0]    word_a_reg;
    logic [WORD_W-1:0]    word_b_reg;
    logic                 strobe_reg;
    logic                 twos_reg;
    logic                 dcs_reg;
    logic [31:0]          hrdata_reg;
    logic                 hreadyout_reg;
    logic                 hresp_reg;

    wire  [1:0]           eff_sel;
    wire                  sel_twos;
    wire                  sel_dcs;
    wire  [WORD_W-1:0]    coded_a;
    wire  [WORD_W-1:0]    coded_b;
    wire                  running;
    wire                  fill_done;
    wire                  bus_take;
    wire  [`AFS_ADDR_W-1:0] bus_addr;
    wire                  take_read;
    wire                  take_write;
    wire                  pop_data;
    wire                  wr_ctrl;
    wire                  wr_status;
    wire                  push_try;
    wire                  push_lost;
    wire                  ovf_clear;
    wire  [31:0]          status_word;
    wire  [31:0]          rd_mux;

    // ------------------------------------------------------------------
    // select decode
    // ------------------------------------------------------------------
    // serial enable hands the select over to the control register
    assign eff_sel  = I_SERIAL_EN ? ctrl_sel_reg : I_FORMAT_STABILIZER_SELECT;
    // coding follows the upper select bit, the stabilizer the middle levels
    assign sel_twos = (eff_sel == AFS_SEL_SUPPLY) ||
                      (eff_sel == AFS_SEL_TWO_THIRDS);
    assign sel_dcs  = (eff_sel == AFS_SEL_ONE_THIRD) ||
                      (eff_sel == AFS_SEL_TWO_THIRDS);

    // ------------------------------------------------------------------
    // coding pipeline
    // ------------------------------------------------------------------
    // a select change shows after the pipeline drains
    afs_coder #(
        .RAW_W   (RAW_W),
        .WORD_W  (WORD_W),
        .LATENCY (LATENCY)
    ) afs_coder_inst (
        .i_clk    (I_CLOCK),
        .i_rst_n  (I_RESET_N),
        .i_ce     (I_CE),
        .i_raw_a  (I_SAMPLE_A),
        .i_raw_b  (I_SAMPLE_B),
        .i_twos   (sel_twos),
        .o_word_a (coded_a),
        .o_word_b (coded_b)
    );

    // ------------------------------------------------------------------
    // run sequencing
    // ------------------------------------------------------------------
    assign running   = (state_reg == AFS_ST_RUN);
    assign fill_done = (fill_cnt_reg == CNT_W'(LATENCY - 1));

    always_comb begin
        state_next    = state_reg;
        fill_cnt_next = fill_cnt_reg;
        case (state_reg)
            AFS_ST_IDLE: begin
                fill_cnt_next = '0;
                if (!I_POWER_DOWN_INPUT) begin
                    state_next = AFS_ST_FILL;
                end
            end
            AFS_ST_FILL: begin
                fill_cnt_next = fill_cnt_reg + CNT_W'(1);
                if (I_POWER_DOWN_INPUT) begin
                    state_next = AFS_ST_IDLE;
                end else if (fill_done) begin
                    state_next = AFS_ST_RUN;
                end
            end
            AFS_ST_RUN: begin
                if (I_POWER_DOWN_INPUT) begin
                    state_next = AFS_ST_IDLE;
                end
            end
            default: begin
                state_next    = AFS_ST_IDLE;
                fill_cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            state_reg    <= AFS_ST_IDLE;
            fill_cnt_reg <= '0;
        end else if (I_CE) begin
            state_reg    <= state_next;
            fill_cnt_reg <= fill_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------------
    // words refresh every sample; strobe marks them valid while running
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            word_a_reg <= '0;
            word_b_reg <= '0;
            strobe_reg <= 1'b0;
            twos_reg   <= 1'b0;
            dcs_reg    <= 1'b0;
        end else if (I_CE) begin
            word_a_reg <= coded_a;
            word_b_reg <= coded_b;
            strobe_reg <= (state_next == AFS_ST_RUN);
            twos_reg   <= sel_twos;
            dcs_reg    <= sel_dcs;
        end
    end

    assign O_CHANNEL_A_WORD        = word_a_reg;
    assign O_CHANNEL_B_WORD        = word_b_reg;
    assign O_OUTPUT_WORD_STROBE    = strobe_reg;
    assign O_TWOS_COMPLEMENT       = twos_reg;
    assign O_DUTY_CYCLE_STABILIZER = dcs_reg;

    // ------------------------------------------------------------------
    // capture FIFO
    // ------------------------------------------------------------------
    // pins show the word one cycle late; push the pin value
    assign push_try         = I_CE & running & ctrl_capture_reg & strobe_reg;
    assign push_lost        = push_try & ~fifo_if.wr_ready;
    assign fifo_if.wr_valid = push_try;
    assign fifo_if.wr_data  = {word_b_reg, word_a_reg};
    assign fifo_if.rd_ready = pop_data;

    afs_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) afs_fifo_inst (
        .i_clk   (I_CLOCK),
        .i_rst_n (I_RESET_N),
        .i_ce    (I_CE),
        .s       (fifo_if.fifo)
    );

    // ------------------------------------------------------------------
    // AHB-Lite address and data phase
    // ------------------------------------------------------------------
    assign bus_take   = I_HSEL & I_HTRANS[1] & I_HREADY & (I_HSIZE == `AFS_HSIZE_WORD);
    assign bus_addr   = I_HADDR[`AFS_ADDR_W-1:0];
    assign take_read  = bus_take & ~I_HWRITE;
    assign take_write = bus_take & I_HWRITE;
    assign pop_data   = take_read & (bus_addr == `AFS_ADDR_DATA);
    assign wr_ctrl    = wr_pend_reg & (addr_reg == `AFS_ADDR_CTRL);
    assign wr_status  = wr_pend_reg & (addr_reg == `AFS_ADDR_STATUS);
    assign ovf_clear  = wr_status & I_HWDATA[`AFS_STAT_OVF_BIT];
    // a lost push in the clearing cycle keeps the flag set
    assign ovf_next   = push_lost | (ovf_reg & ~ovf_clear);

    assign status_word = {23'h000000,
                          running,
                          fifo_if.level,
                          ~fifo_if.rd_valid,
                          ovf_reg,
                          sel_dcs,
                          sel_twos};

    assign rd_mux =
        (bus_addr == `AFS_ADDR_CTRL)    ? {29'h00000000, ctrl_capture_reg, ctrl_sel_reg} :
        (bus_addr == `AFS_ADDR_STATUS)  ? status_word :
        (bus_addr == `AFS_ADDR_DATA)    ? (fifo_if.rd_valid ?
                                           32'(fifo_if.rd_data) : 32'h00000000) :
        (bus_addr == `AFS_ADDR_LATENCY) ? 32'(LATENCY) :
                                          32'h00000000;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= '0;
            hrdata_reg  <= 32'h00000000;
        end else if (I_CE) begin
            wr_pend_reg <= take_write;
            if (bus_take) begin
                addr_reg <= bus_addr;
            end
            if (take_read) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // control and status registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            ctrl_sel_reg     <= 2'(`AFS_CTRL_RESET);
            ctrl_capture_reg <= 1'(`AFS_CTRL_RESET >> `AFS_CTRL_CAPTURE_BIT);
            ovf_reg          <= 1'b0;
        end else if (I_CE) begin
            if (wr_ctrl) begin
                ctrl_sel_reg     <= I_HWDATA[`AFS_CTRL_SEL_MSB:`AFS_CTRL_SEL_LSB];
                ctrl_capture_reg <= I_HWDATA[`AFS_CTRL_CAPTURE_BIT];
            end
            ovf_reg <= ovf_next;
        end
    end

    // zero-wait slave; response always OKAY
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESET_N) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    assign O_HRDATA    = hrdata_reg;
    assign O_HREADYOUT = hreadyout_reg;
    assign O_HRESP     = hresp_reg;

endmodule : afs_top

// file: sim/afs_capture_model.sv
/*
 * Capture logic that latches the parallel word pair.
 * Assumes the strobe and words are registered on the same clock.
 */
`timescale 1ns/100ps
module afs_capture_model #(
    parameter int WORD_W = 12
) (
    // clock and qualifiers
    input  wire logic              i_clk,
    input  wire logic              i_pd,
    input  wire logic              i_strobe,
    // words in, latched words out
    input  wire logic [WORD_W-1:0] i_word_a,
    input  wire logic [WORD_W-1:0] i_word_b,
    output logic      [WORD_W-1:0] o_cap_a,
    output logic      [WORD_W-1:0] o_cap_b
);
    // only strobed words with power-down low are taken
    always @(posedge i_clk) begin
        if (i_strobe === 1'b1 && i_pd === 1'b0) begin
            o_cap_a <= i_word_a;
            o_cap_b <= i_word_b;
        end
    end
endmodule : afs_capture_model

// file: sim/afs_top_props.sv
/*
 * Pin-level assertions of the converter output-format block.
 * Assumes binding to afs_top; the whole checker runs on I_CLOCK.
 */
`timescale 1ns/100ps
module afs_top_props #(
    parameter int RAW_W   = 14,
    parameter int WORD_W  = 12,
    parameter int LATENCY = 8
) (
    // clock, reset, enable
    input wire logic              I_CLOCK,
    input wire logic              I_RESET_N,
    input wire logic              I_CE,
    // converter side
    input wire logic [RAW_W-1:0]  I_SAMPLE_A,
    input wire logic [RAW_W-1:0]  I_SAMPLE_B,
    input wire logic [1:0]        I_FORMAT_STABILIZER_SELECT,
    input wire logic              I_SERIAL_EN,
    input wire logic              I_POWER_DOWN_INPUT,
    // output words
    input wire logic [WORD_W-1:0] O_CHANNEL_A_WORD,
    input wire logic [WORD_W-1:0] O_CHANNEL_B_WORD,
    input wire logic              O_OUTPUT_WORD_STROBE,
    input wire logic              O_TWOS_COMPLEMENT,
    input wire logic              O_DUTY_CYCLE_STABILIZER
);
    localparam int LAG = LATENCY + 1;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    sequence s_pin(logic [1:0] v);
        I_CE && !I_SERIAL_EN && I_FORMAT_STABILIZER_SELECT == v;
    endsequence
    sequence s_run;
        O_OUTPUT_WORD_STROBE && I_CE && !I_POWER_DOWN_INPUT;
    endsequence

    chk_supply_twos: assert property (s_pin(2'h3) |=> O_TWOS_COMPLEMENT
        && !O_DUTY_CYCLE_STABILIZER) else $error("supply select decoded wrongly");
    chk_ground_offset: assert property (s_pin(2'h0) |=> !O_TWOS_COMPLEMENT
        && !O_DUTY_CYCLE_STABILIZER) else $error("ground select decoded wrongly");
    chk_upper_level: assert property (s_pin(2'h2) |=> O_TWOS_COMPLEMENT
        && O_DUTY_CYCLE_STABILIZER) else $error("two-thirds select decoded wrongly");
    chk_lower_level: assert property (s_pin(2'h1) |=> !O_TWOS_COMPLEMENT
        && O_DUTY_CYCLE_STABILIZER) else $error("one-third select decoded wrongly");
    chk_pos_clip: assert property (I_CE && $signed(I_SAMPLE_A) > 2047
        |-> ##LAG O_CHANNEL_A_WORD[10:0] == 11'h7FF) else $error("no positive clip");
    chk_neg_clip: assert property (I_CE && $signed(I_SAMPLE_A) < -2048
        |-> ##LAG O_CHANNEL_A_WORD[10:0] == 11'h000) else $error("no negative clip");
    chk_lanes_equal: assert property (I_CE && I_SAMPLE_A == I_SAMPLE_B
        |-> ##LAG O_CHANNEL_A_WORD == O_CHANNEL_B_WORD) else $error("channel lag differs");
    chk_pd_quiet: assert property (I_CE && I_POWER_DOWN_INPUT
        |=> !O_OUTPUT_WORD_STROBE) else $error("strobe high in power-down");
    chk_strobe_holds: assert property (s_run |=> O_OUTPUT_WORD_STROBE)
        else $error("word stream stopped");
endmodule : afs_top_props

bind afs_top afs_top_props #(.RAW_W(RAW_W), .WORD_W(WORD_W), .LATENCY(LATENCY))
    afs_top_props_inst (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_CE(I_CE),
    .I_SAMPLE_A(I_SAMPLE_A), .I_SAMPLE_B(I_SAMPLE_B), .I_SERIAL_EN(I_SERIAL_EN),
    .I_FORMAT_STABILIZER_SELECT(I_FORMAT_STABILIZER_SELECT),
    .I_POWER_DOWN_INPUT(I_POWER_DOWN_INPUT), .O_CHANNEL_A_WORD(O_CHANNEL_A_WORD),
    .O_CHANNEL_B_WORD(O_CHANNEL_B_WORD), .O_OUTPUT_WORD_STROBE(O_OUTPUT_WORD_STROBE),
    .O_TWOS_COMPLEMENT(O_TWOS_COMPLEMENT),
    .O_DUTY_CYCLE_STABILIZER(O_DUTY_CYCLE_STABILIZER));

// file: sim/test_adc_output_format_select.sv
/*
 * Self-checking bench of the output-format block with its capture model.
 * Assumes a single AHB-Lite slave that never stalls the bus for long.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module test_adc_output_format_select import afs_pkg::*;;
    localparam int LAT = 2;
    logic        clk, rst_n, ser_en, pd, hsel, hwrite, strobe, twos, duty_cycle_stabilizer, hresp, ce;
    logic [13:0] smp_a, smp_b;
    logic [1:0]  sel, htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [11:0] word_a, word_b, cap_a, cap_b;
    wire         hready;
    int          failures, tests_run;
    logic [1:0]  sel_exp [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [13:0] smp_tab [5] = '{14'h3800, 14'h0000, 14'h07FF, 14'h3000, 14'h0FFF};
    logic [11:0] exp_off [5] = '{12'h000, 12'h800, 12'hFFF, 12'h000, 12'hFFF};
    logic [11:0] exp_two [5] = '{12'h800, 12'h000, 12'h7FF, 12'h800, 12'h7FF};

    afs_top #(.LATENCY(LAT)) afs_top_inst (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CE(ce),
        .I_SAMPLE_A(smp_a), .I_SAMPLE_B(smp_b), .I_FORMAT_STABILIZER_SELECT(sel),
        .I_SERIAL_EN(ser_en), .I_POWER_DOWN_INPUT(pd), .O_CHANNEL_A_WORD(word_a),
        .O_CHANNEL_B_WORD(word_b), .O_OUTPUT_WORD_STROBE(strobe), .O_TWOS_COMPLEMENT(twos),
        .O_DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp));
    afs_capture_model #(.WORD_W(12)) afs_capture_model_inst (.i_clk(clk), .i_pd(pd),
        .i_strobe(strobe), .i_word_a(word_a), .i_word_b(word_b), .o_cap_a(cap_a),
        .o_cap_b(cap_b));

    // ------------------------------------------------------------------
    // bus and closing tasks
    // ------------------------------------------------------------------
    task bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus_xfer
    task bus_rd(input logic [31:0] addr, input logic [31:0] exp);
        bus_xfer(1'b0, addr, 32'h0);
        `CHK(rd, exp)
        `CHK(hresp, 1'b0)
    endtask : bus_rd
    task bus_wr(input logic [31:0] addr, input logic [31:0] data);
        bus_xfer(1'b1, addr, data);
    endtask : bus_wr
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        failures++;
        tally_and_finish;
    end

    initial begin
        failures = 0;
        tests_run = 0;
        {rst_n, ser_en, pd, hsel, hwrite, htrans, haddr, hwdata} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        sel = AFS_SEL_GROUND;
        smp_a = 14'h0100;
        smp_b = 14'h0100;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // fifo overfills while running, then capture is switched off
        repeat (30) @(posedge clk);
        bus_wr(32'h0, 32'h0);
        bus_rd(32'h4, 32'h184);
        repeat (8) bus_rd(32'h8, 32'h00900900);
        bus_rd(32'h8, 32'h0);
        bus_rd(32'h4, 32'h10C);
        bus_wr(32'h4, 32'h4);
        bus_rd(32'h4, 32'h108);
        bus_rd(32'hC, LAT);
        bus_rd(32'h10, 32'h0);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            sel <= s[1:0];
            repeat (2) @(posedge clk);
            `CHK({twos, duty_cycle_stabilizer}, sel_exp[s])
        end
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 5; i++) begin
                @(posedge clk);
                sel <= (c == 1) ? AFS_SEL_SUPPLY : AFS_SEL_GROUND;
                smp_a <= smp_tab[i];
                smp_b <= smp_tab[i];
                repeat (LAT + 3) @(posedge clk);
                `CHK(cap_a, (c == 1) ? exp_two[i] : exp_off[i])
                `CHK(cap_b, (c == 1) ? exp_two[i] : exp_off[i])
            end
        end
        // serial select overrides the pin
        @(posedge clk);
        sel <= AFS_SEL_GROUND;
        ser_en <= 1'b1;
        bus_wr(32'h0, 32'h3);
        repeat (2) @(posedge clk);
        `CHK({twos, duty_cycle_stabilizer}, 2'h2)
        bus_rd(32'h0, 32'h3);
        ser_en <= 1'b0;
        pd <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(strobe, 1'b0)
        pd <= 1'b0;
        repeat (LAT + 4) @(posedge clk);
        `CHK(strobe, 1'b1)
        // enable low freezes the run state
        ce <= 1'b0;
        pd <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(strobe, 1'b1)
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(strobe, 1'b0)
        tally_and_finish;
    end
endmodule : test_adc_output_format_select
